// >>> hdl/sop_defs.svh
// register offsets, field positions, byte values and counts for section overhead block
`ifndef SOP_DEFS_SVH
`define SOP_DEFS_SVH
`define SOP_OFF_GENERAL_CONFIG   8'h00
`define SOP_OFF_ERROR_INSERT     8'h06
`define SOP_OFF_TX_SECTION_CTRL  8'h0C
`define SOP_OFF_TX_LINE_CTRL     8'h0D
`define SOP_OFF_SECTION_IRQ      8'h3D
`define SOP_OFF_RX_SECTION_STATE 8'h45
`define SOP_OFF_PARITY_ERRS_LO   8'h54
`define SOP_OFF_PARITY_ERRS_HI   8'h55
`define SOP_OFF_TX_TRACE_BUF     8'h68
`define SOP_OFF_RX_TRACE_BUF     8'h6A
`define SOP_RST_REG              8'h00
`define SOP_BIT_SDH_MODE         0
`define SOP_BIT_STAT_PIN_MODE    2
`define SOP_BIT_INVERT_A1        7
`define SOP_BIT_FRAMING_OFF      4
`define SOP_BIT_TRACE_OFF        5
`define SOP_BIT_FORCE_LINE_ALARM 3
`define SOP_BIT_FORCE_BAD_PTR    6
`define SOP_BIT_TRACE_CHANGE     1
`define SOP_BIT_LOS              5
`define SOP_BIT_OOF              4
`define SOP_BIT_LOF              3
`define SOP_BIT_B1_MISMATCH      0
`define SOP_STAT_LINE_LOS        7
`define SOP_STAT_LINE_OOF        6
`define SOP_VAL_A1               8'hF6
`define SOP_VAL_A2               8'h28
`define SOP_VAL_GROWTH1          8'h02
`define SOP_VAL_GROWTH2          8'h03
`define SOP_VAL_H1_FIRST_SONET   8'h62
`define SOP_VAL_H1_FIRST_SDH     8'h6A
`define SOP_VAL_H1_OTHER         8'h93
`define SOP_VAL_H2_FIRST         8'h0A
`define SOP_VAL_H2_OTHER         8'hFF
`define SOP_VAL_BAD_PTR          8'h33
`define SOP_VAL_ALL_ONES         8'hFF
`define SOP_LOS_ZERO_OCTETS      11'd1620
`define SOP_OOF_BAD_FRAMES       3'd4
`define SOP_LOF_OOF_FRAMES       5'd24
`define SOP_FRAME_COLS           9'd270
`define SOP_FRAME_ROWS           4'd9
`define SOP_FRAME_BYTES          12'd2430
`define SOP_OH_COLS              9'd9
`define SOP_TRACE_LEN            64
`endif

// >>> hdl/sop_pkg.sv
// shared types of the section overhead block
package sop_pkg;
  // receive framer state, gray along hunt -> sync
  typedef enum logic [0:0] {
    FR_HUNT = 1'b0,
    FR_SYNC = 1'b1
  } sop_fr_e;
  typedef logic [7:0] sop_byte_t;
endpackage

// >>> hdl/sop_skid.sv
// two-entry payload buffer with valid and ready on both sides
`timescale 1ns/100ps
module sop_skid #(
  parameter int W = 8,
  parameter int D = 2
) (
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  // fill side
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output      logic         in_ready_out,
  // drain side
  output      logic         out_valid_out,
  output      logic [W-1:0] out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } sop_skid_st_s;
  sop_skid_st_s st_q;
  sop_skid_st_s st_d;
  logic push;
  logic pop;

  // honest full and empty straight from the count
  assign in_ready_out  = (st_q.cnt != (AW+1)'(D)); // count is one bit wider than a pointer
  assign out_valid_out = (st_q.cnt != '0);
  assign out_data_out  = st_q.mem[st_q.rp];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_ready_in & out_valid_out;

  // pointer and count update, wrap at depth
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = in_data_in;
      st_d.wp = (st_q.wp == AW'(D - 1)) ? '0 : st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = (st_q.rp == AW'(D - 1)) ? '0 : st_q.rp + 1'b1;
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// >>> hdl/sop_top.sv
// section overhead processor: rx framing, los, b1, trace; tx overhead and pointer bytes
//
// Contract
// - declare loss of signal after 1620 consecutive zero line octets
// - clear loss of signal after two framing words with no new detection between
// - loss of signal shows in bit 5 of receive section status at 0x45
// - with status pin mode bit set, loss of signal drives status line 7
// - four bad-framing frames in a row declare out-of-frame, line 6 and bit 4
// - one frame with matching framing bytes returns to in-frame
// - transmit F6/28 framing, or zeros when tx section control bit 4 set
// - error insert bit 7 inverts transmitted A1 bytes
// - out-of-frame for 24 frames declares loss of frame, bit 3, clears with it
// - transmit B1 is even BIP-8 over every bit of the previous frame
// - receive B1 parity per frame checked against next frame's B1 byte
// - section parity bit errors count in 16 bits, low 0x54, high 0x55
// - error count latched on low read while the live counter restarts from zero and keeps counting
// - transmit trace byte from circular 64-byte buffer repeating continuously
// - trace disabled by tx section control bit 5 sends zero trace bytes
// - transmit trace buffer at 0x68, receive trace buffer at 0x6A
// - received trace differing from stored one sets bit 1 at 0x3D
// - growth bytes sent as 02 and 03, not checked on receive
// - pointer bytes fixed: H1 first 62 or 6A, others 93, H3 zero
// - tx line control bit 3 forces all pointer bytes to all ones
// - tx line control bit 6 replaces first H1 with 33
`timescale 1ns/100ps
`include "sop_defs.svh"
module sop_top #(
  parameter int PAY_DEPTH = 2
) (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // microprocessor port
  input  wire logic       cpu_cs_in,
  input  wire logic       cpu_wr_in,
  input  wire logic       cpu_rd_in,
  input  wire logic [7:0] cpu_addr_in,
  input  wire logic [7:0] cpu_wdata_in,
  output      logic [7:0] cpu_rdata_out,
  // receive line octets
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_octet_in,
  // transmit payload source
  input  wire logic       pay_valid_in,
  input  wire logic [7:0] pay_data_in,
  output      logic       pay_ready_out,
  // transmit line octets
  output      logic [7:0] tx_octet_out,
  output      logic       tx_sof_out,
  // status pins
  output      logic [7:0] status_output_lines_out
);
  typedef struct packed {
    logic [7:0]            gen;
    logic [7:0]            error_insert_ctrl;
    logic [7:0]            tx_section_ctrl;
    logic [7:0]            tx_line_ctrl;
    logic [7:0]            irq;
    logic [7:0]            rdata;
    logic [63:0][7:0]      txbuf;
    logic [63:0][7:0]      rxbuf;
    logic [5:0]            tx_acc;
    logic [5:0]            rx_acc;
    logic [5:0]            tx_j0;
    logic [5:0]            rx_j0;
    logic                  trace_diff;
    sop_pkg::sop_fr_e      fr;
    logic [11:0]           rpos;
    logic [39:0]           sh;
    logic [2:0]            bad_cnt;
    logic [4:0]            lof_cnt;
    logic                  lof;
    logic [10:0]           zrun;
    logic                  los;
    logic                  fw_seen;
    sop_pkg::sop_byte_t    rpar;
    sop_pkg::sop_byte_t    rprev;
    logic                  rprev_ok;
    logic                  b1err;
    logic [15:0]           b1cnt;
    logic [15:0]           b1hold;
    logic [8:0]            tcol;
    logic [3:0]            trow;
    sop_pkg::sop_byte_t    tpar;
    sop_pkg::sop_byte_t    tprev;
    sop_pkg::sop_byte_t    tx_byte;
    logic                  tx_sof;
    logic [7:0]            stat;
  } sop_st_s;

  sop_st_s            st_q;
  sop_st_s            st_d;
  logic               pl_valid;
  logic [7:0]         pl_data;
  logic               pl_pop;

  // count of ones in a byte, used to turn a parity mismatch into bit errors
  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'b000, v[i]};
    end
    return n;
  endfunction

  // payload buffer: a stall at an overhead column holds words rather than dropping them
  sop_skid #(
    .W (8),
    .D (PAY_DEPTH)
  ) u_pay_buf (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .in_valid_in   (pay_valid_in),
    .in_data_in    (pay_data_in),
    .in_ready_out  (pay_ready_out),
    .out_valid_out (pl_valid),
    .out_data_out  (pl_data),
    .out_ready_in  (pl_pop)
  );

  // payload is drained only in payload columns
  assign pl_pop = (st_q.tcol >= `SOP_OH_COLS);

  // next-state logic for the whole block
  always_comb begin
    logic        wr;
    logic        rd;
    logic [47:0] win;
    logic        hit;
    logic [11:0] nxt;
    logic [7:0]  par_now;
    logic [3:0]  errs;
    logic [16:0] sum;
    logic [7:0]  ob;
    logic        clr_trace;
    logic        set_trace;
    logic        lo_read;
    wr = 1'b0;
    rd = 1'b0;
    win = '0;
    hit = 1'b0;
    nxt = '0;
    par_now = '0;
    errs = 4'h0;
    sum = '0;
    ob = 8'h00;
    clr_trace = 1'b0;
    set_trace = 1'b0;
    lo_read = 1'b0;
    st_d = st_q;
    wr = cpu_cs_in & cpu_wr_in;
    rd = cpu_cs_in & cpu_rd_in;

    // ---------------- receive side ----------------
    win = {st_q.sh, rx_octet_in};
    hit = (win == {{3{`SOP_VAL_A1}}, {3{`SOP_VAL_A2}}});
    if (rx_valid_in) begin
      st_d.sh = win[39:0];
      nxt = (st_q.rpos == `SOP_FRAME_BYTES - 12'd1) ? 12'd0 : st_q.rpos + 12'd1;
      st_d.rpos = nxt;

      // zero-octet run and loss of signal
      if (rx_octet_in == 8'h00) begin
        if (st_q.zrun != `SOP_LOS_ZERO_OCTETS) begin
          st_d.zrun = st_q.zrun + 11'd1;
        end
        if (st_q.zrun == `SOP_LOS_ZERO_OCTETS - 11'd1) begin
          st_d.los = 1'b1;
          st_d.fw_seen = 1'b0; // new detection restarts the clear sequence
        end
      end else begin
        st_d.zrun = '0;
      end
      if (st_q.los && hit) begin
        st_d.fw_seen = 1'b1;
        if (st_q.fw_seen) begin
          st_d.los = 1'b0; // second framing word with no detection between
          st_d.fw_seen = 1'b0;
        end
      end

      // framing state machine
      case (st_q.fr)
        sop_pkg::FR_HUNT: begin
          if (hit) begin
            st_d.fr = sop_pkg::FR_SYNC; // one matching frame is enough
            st_d.rpos = 12'd6;
            st_d.bad_cnt = '0;
            st_d.lof_cnt = '0;
            st_d.lof = 1'b0; // loss of frame clears with out-of-frame
            // framing word already passed: seed parity with it so the first frame is whole
            st_d.rpar = `SOP_VAL_A1 ^ `SOP_VAL_A2;
            st_d.rprev_ok = 1'b0;
          end else if (st_q.rpos == 12'd5) begin
            // frame persistence while out of frame
            if (st_q.lof_cnt != `SOP_LOF_OOF_FRAMES) begin
              st_d.lof_cnt = st_q.lof_cnt + 5'd1;
            end
            if (st_q.lof_cnt == `SOP_LOF_OOF_FRAMES - 5'd1) begin
              st_d.lof = 1'b1;
            end
          end
        end
        sop_pkg::FR_SYNC: begin
          if (st_q.rpos == 12'd5) begin
            if (hit) begin
              st_d.bad_cnt = '0;
            end else begin
              st_d.bad_cnt = st_q.bad_cnt + 3'd1;
              if (st_q.bad_cnt == `SOP_OOF_BAD_FRAMES - 3'd1) begin
                st_d.fr = sop_pkg::FR_HUNT;
                st_d.lof_cnt = 5'd1;
              end
            end
          end
        end
        default: st_d.fr = sop_pkg::FR_HUNT;
      endcase

      // section parity over the received frame, checked at the next B1
      if (st_q.fr == sop_pkg::FR_SYNC) begin
        par_now = st_q.rpar ^ rx_octet_in;
        st_d.rpar = par_now;
        if (st_q.rpos == `SOP_FRAME_BYTES - 12'd1) begin
          st_d.rprev = par_now;
          st_d.rprev_ok = 1'b1;
          st_d.rpar = '0;
        end
        if (st_q.rpos == 12'({3'b000, `SOP_FRAME_COLS}) && st_q.rprev_ok) begin
          errs = ones8(st_q.rprev ^ rx_octet_in);
          st_d.b1err = (errs != 4'h0);
        end
        // trace byte: compare with what the last message left here
        if (st_q.rpos == 12'd6) begin
          if (st_q.rxbuf[st_q.rx_j0] != rx_octet_in) begin
            st_d.trace_diff = 1'b1;
          end
          st_d.rxbuf[st_q.rx_j0] = rx_octet_in;
          st_d.rx_j0 = st_q.rx_j0 + 6'd1;
          if (st_q.rx_j0 == 6'd63) begin
            set_trace = st_q.trace_diff | (st_q.rxbuf[st_q.rx_j0] != rx_octet_in);
            st_d.trace_diff = 1'b0;
          end
        end
        // growth bytes at positions 7 and 8 are deliberately not examined
      end
    end

    // ---------------- transmit side ----------------
    // row and column of the byte being built now
    if (st_q.tcol == `SOP_FRAME_COLS - 9'd1) begin
      st_d.tcol = '0;
      st_d.trow = (st_q.trow == `SOP_FRAME_ROWS - 4'd1) ? 4'd0 : st_q.trow + 4'd1;
    end else begin
      st_d.tcol = st_q.tcol + 9'd1;
    end
    if (st_q.tcol >= `SOP_OH_COLS) begin
      ob = pl_valid ? pl_data : 8'h00; // an empty buffer sends idle zeros
    end else if (st_q.trow == 4'd0) begin
      case (st_q.tcol)
        9'd0, 9'd1, 9'd2: begin
          ob = `SOP_VAL_A1;
          if (st_q.error_insert_ctrl[`SOP_BIT_INVERT_A1]) begin
            ob = ~`SOP_VAL_A1;
          end
          if (st_q.tx_section_ctrl[`SOP_BIT_FRAMING_OFF]) begin
            ob = 8'h00;
          end
        end
        9'd3, 9'd4, 9'd5: begin
          ob = st_q.tx_section_ctrl[`SOP_BIT_FRAMING_OFF] ? 8'h00 : `SOP_VAL_A2;
        end
        9'd6: begin
          // trace off still walks the index so re-enable resumes in step
          ob = st_q.tx_section_ctrl[`SOP_BIT_TRACE_OFF] ? 8'h00 : st_q.txbuf[st_q.tx_j0];
          st_d.tx_j0 = st_q.tx_j0 + 6'd1; // wraps at 64 so the message repeats
        end
        9'd7:    ob = `SOP_VAL_GROWTH1;
        9'd8:    ob = `SOP_VAL_GROWTH2;
        default: ob = 8'h00;
      endcase
    end else if (st_q.trow == 4'd1 && st_q.tcol == 9'd0) begin
      ob = st_q.tprev;
    end else if (st_q.trow == 4'd3) begin
      case (st_q.tcol)
        9'd0: begin
          ob = st_q.gen[`SOP_BIT_SDH_MODE] ? `SOP_VAL_H1_FIRST_SDH
                                            : `SOP_VAL_H1_FIRST_SONET;
          if (st_q.tx_line_ctrl[`SOP_BIT_FORCE_BAD_PTR]) begin
            ob = `SOP_VAL_BAD_PTR;
          end
        end
        9'd1, 9'd2: ob = `SOP_VAL_H1_OTHER;
        9'd3:       ob = `SOP_VAL_H2_FIRST;
        9'd4, 9'd5: ob = `SOP_VAL_H2_OTHER;
        default:    ob = 8'h00; // H3 bytes
      endcase
      if (st_q.tx_line_ctrl[`SOP_BIT_FORCE_LINE_ALARM]) begin
        ob = `SOP_VAL_ALL_ONES; // alarm wins over the bad pointer
      end
    end else begin
      ob = 8'h00;
    end
    st_d.tx_byte = ob;
    st_d.tx_sof = (st_q.trow == 4'd0) && (st_q.tcol == 9'd0);
    // transmit parity covers every outgoing byte of the frame
    if (st_q.trow == `SOP_FRAME_ROWS - 4'd1 && st_q.tcol == `SOP_FRAME_COLS - 9'd1) begin
      st_d.tprev = st_q.tpar ^ ob;
      st_d.tpar = '0;
    end else begin
      st_d.tpar = st_q.tpar ^ ob;
    end

    // ---------------- register port ----------------
    st_d.rdata = 8'h00;
    if (rd) begin
      case (cpu_addr_in)
        `SOP_OFF_GENERAL_CONFIG:   st_d.rdata = st_q.gen;
        `SOP_OFF_ERROR_INSERT:     st_d.rdata = st_q.error_insert_ctrl;
        `SOP_OFF_TX_SECTION_CTRL:  st_d.rdata = st_q.tx_section_ctrl;
        `SOP_OFF_TX_LINE_CTRL:     st_d.rdata = st_q.tx_line_ctrl;
        `SOP_OFF_SECTION_IRQ: begin
          st_d.rdata = st_q.irq;
          clr_trace = 1'b1;
        end
        `SOP_OFF_RX_SECTION_STATE: begin
          st_d.rdata[`SOP_BIT_LOS] = st_q.los;
          st_d.rdata[`SOP_BIT_OOF] = (st_q.fr == sop_pkg::FR_HUNT);
          st_d.rdata[`SOP_BIT_LOF] = st_q.lof;
          st_d.rdata[`SOP_BIT_B1_MISMATCH] = st_q.b1err;
        end
        `SOP_OFF_PARITY_ERRS_LO: begin
          st_d.rdata = st_q.b1cnt[7:0];
          lo_read = 1'b1;
        end
        `SOP_OFF_PARITY_ERRS_HI:   st_d.rdata = st_q.b1hold[15:8];
        `SOP_OFF_TX_TRACE_BUF: begin
          st_d.rdata = st_q.txbuf[st_q.tx_acc];
          st_d.tx_acc = st_q.tx_acc + 6'd1;
        end
        `SOP_OFF_RX_TRACE_BUF: begin
          st_d.rdata = st_q.rxbuf[st_q.rx_acc];
          st_d.rx_acc = st_q.rx_acc + 6'd1;
        end
        default: st_d.rdata = 8'h00;
      endcase
    end
    if (wr) begin
      case (cpu_addr_in)
        `SOP_OFF_GENERAL_CONFIG:  st_d.gen = cpu_wdata_in;
        `SOP_OFF_ERROR_INSERT:    st_d.error_insert_ctrl = cpu_wdata_in;
        `SOP_OFF_TX_SECTION_CTRL: st_d.tx_section_ctrl = cpu_wdata_in;
        `SOP_OFF_TX_LINE_CTRL:    st_d.tx_line_ctrl = cpu_wdata_in;
        `SOP_OFF_TX_TRACE_BUF: begin
          // message is loaded here before trace is enabled
          st_d.txbuf[st_q.tx_acc] = cpu_wdata_in;
          st_d.tx_acc = st_q.tx_acc + 6'd1;
        end
        default: st_d.gen = st_d.gen;
      endcase
    end

    // trace-change flag: a new change in the read cycle survives the clear
    st_d.irq[`SOP_BIT_TRACE_CHANGE] =
      (st_q.irq[`SOP_BIT_TRACE_CHANGE] & ~clr_trace) | set_trace;

    // error counter: snapshot on low read, live count restarts with this cycle's errors
    sum = (lo_read ? 17'd0 : {1'b0, st_q.b1cnt}) + {13'd0, errs};
    st_d.b1cnt = sum[16] ? 16'hFFFF : sum[15:0];
    if (lo_read) begin
      st_d.b1hold = st_q.b1cnt; // no error lost across the read
    end

    // status lines, registered so the pins never glitch
    st_d.stat = 8'h00;
    st_d.stat[`SOP_STAT_LINE_LOS] = st_d.los & st_q.gen[`SOP_BIT_STAT_PIN_MODE];
    st_d.stat[`SOP_STAT_LINE_OOF] = (st_d.fr == sop_pkg::FR_HUNT);
  end

  // single state register; out-of-frame and no-signal-free start after reset
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.gen <= `SOP_RST_REG;
      st_q.error_insert_ctrl <= `SOP_RST_REG;
      st_q.tx_section_ctrl <= `SOP_RST_REG;
      st_q.tx_line_ctrl <= `SOP_RST_REG;
      st_q.fr <= sop_pkg::FR_HUNT;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign cpu_rdata_out           = st_q.rdata;
  assign tx_octet_out            = st_q.tx_byte;
  assign tx_sof_out              = st_q.tx_sof;
  assign status_output_lines_out = st_q.stat;
endmodule

// >>> tb/sop_top_asserts.sv
// port checker for the section overhead block
`timescale 1ns/100ps
module sop_chk (
  // clock, reset, cpu port, line and status
  input wire logic       clk_sys_in,
  input wire logic       rst_in,
  input wire logic       cpu_cs_in,
  input wire logic       cpu_wr_in,
  input wire logic       cpu_rd_in,
  input wire logic [7:0] cpu_addr_in,
  input wire logic [7:0] cpu_wdata_in,
  input wire logic [7:0] cpu_rdata_out,
  input wire logic [7:0] tx_octet_out,
  input wire logic       tx_sof_out,
  input wire logic [7:0] status_output_lines_out
);
  logic [7:0]  gen_q, ins_q, sec_q, lin_q, acc_q, prv_q;
  logic [11:0] pos_q;
  logic [3:0]  qt_q;
  logic        seen_q, full_q, ok, we;
  assign we = cpu_cs_in && cpu_wr_in;
  assign ok = seen_q && (qt_q == 4'hF);
  // shadow controls and frame position; checks other than frame length, b1 and read idle skip a quiet spell after writes
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      {gen_q, ins_q, sec_q, lin_q} <= '0;
      {acc_q, prv_q, pos_q, qt_q, seen_q, full_q} <= '0;
    end else begin
      if (we && cpu_addr_in == 8'h00) gen_q <= cpu_wdata_in;
      if (we && cpu_addr_in == 8'h06) ins_q <= cpu_wdata_in;
      if (we && cpu_addr_in == 8'h0C) sec_q <= cpu_wdata_in;
      if (we && cpu_addr_in == 8'h0D) lin_q <= cpu_wdata_in;
      qt_q <= we ? 4'h0 : qt_q + {3'h0, qt_q != 4'hF};
      pos_q <= tx_sof_out ? 12'd1 : pos_q + 12'd1;
      seen_q <= seen_q | tx_sof_out;
      acc_q <= tx_sof_out ? tx_octet_out : acc_q ^ tx_octet_out;
      if (tx_sof_out) {prv_q, full_q} <= {acc_q, seen_q};
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_a1; tx_sof_out && ok |-> tx_octet_out == (sec_q[4] ? 8'h00 : ins_q[7] ? 8'h09 : 8'hF6); endproperty
  a_a1: assert property (p_a1) else $error("a1 byte wrong");
  property p_a2; tx_sof_out && ok |-> ##3 tx_octet_out == (sec_q[4] ? 8'h00 : 8'h28); endproperty
  a_a2: assert property (p_a2) else $error("a2 byte wrong");
  property p_gr; pos_q == 12'd7 && ok |-> tx_octet_out == 8'h02 ##1 tx_octet_out == 8'h03; endproperty
  a_gr: assert property (p_gr) else $error("growth bytes wrong");
  property p_frm; seen_q |-> tx_sof_out == (pos_q == 12'd2430); endproperty
  a_frm: assert property (p_frm) else $error("frame length wrong");
  property p_b1; full_q && pos_q == 12'd270 |-> tx_octet_out == prv_q; endproperty
  a_b1: assert property (p_b1) else $error("b1 parity wrong");
  property p_h1; pos_q == 12'd810 && ok |-> tx_octet_out == (lin_q[3] ? 8'hFF :
    lin_q[6] ? 8'h33 : gen_q[0] ? 8'h6A : 8'h62); endproperty
  a_h1: assert property (p_h1) else $error("first h1 wrong");
  property p_h3; pos_q == 12'd816 && ok |-> tx_octet_out == (lin_q[3] ? 8'hFF : 8'h00); endproperty
  a_h3: assert property (p_h3) else $error("h3 wrong");
  property p_rd; !$past(cpu_cs_in && cpu_rd_in) |-> cpu_rdata_out == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data not idle");
  property p_los; ok && status_output_lines_out[7] |-> gen_q[2]; endproperty
  a_los: assert property (p_los) else $error("los line without pin mode");
endmodule

// >>> tb/sop_far_end.sv
// far-end line terminal sending framed octets
`timescale 1ns/100ps
module sop_far_end (
  // clock, reset and mode: 0 good, 1 bad framing, 2 all zero, 3 bad parity
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic [1:0] mode_in,
  // line octets toward the receiver
  output      logic       rx_valid_out,
  output      logic [7:0] rx_octet_out,
  output      logic       sof_out
);
  logic [11:0] pos = 12'd0;
  logic [1:0]  md = 2'd0;
  logic [7:0]  acc = 8'h00;
  logic [7:0]  prv = 8'h00;
  logic [7:0]  b;
  initial {rx_valid_out, rx_octet_out, sof_out} = 10'h000;
  // octet for this position; filler never forms a framing word
  always_comb begin
    b = pos[7:0] ^ 8'h5A;
    if (pos < 12'd6) b = (pos < 12'd3) ? 8'hF6 : 8'h28;
    if (pos == 12'd270) b = prv ^ {7'h00, md == 2'd3};
    if (md == 2'd2 || (md == 2'd1 && pos < 12'd3)) b = 8'h00;
  end
  // mode is taken only at a frame boundary so bad frames come whole
  always @(posedge clk_sys_in) begin
    rx_valid_out <= !rst_in;
    rx_octet_out <= b;
    sof_out <= pos == 12'd0;
    acc = (pos == 12'd0) ? b : acc ^ b;
    if (pos == 12'd2429) {prv, md} = {acc, mode_in};
    pos = (rst_in || pos == 12'd2429) ? 12'd0 : pos + 12'd1;
  end
endmodule

// >>> tb/test_sonet_section_overhead_proc.sv
// self-checking bench for the section overhead block
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_sonet_section_overhead_proc;
  logic       clk_sys_in, rst_in, cs, wr, rd, pv, prdy, sof, rxv, fsof;
  logic [7:0] addr, wd, rdata, pd, tx, st, rxo, got;
  logic [1:0] mode;
  int         err_count, cmp_count;
  // device and far-end terminal
  sop_top u_sop_top (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cpu_cs_in(cs),
    .cpu_wr_in(wr), .cpu_rd_in(rd), .cpu_addr_in(addr), .cpu_wdata_in(wd),
    .cpu_rdata_out(rdata), .rx_valid_in(rxv), .rx_octet_in(rxo), .pay_valid_in(pv),
    .pay_data_in(pd), .pay_ready_out(prdy), .tx_octet_out(tx), .tx_sof_out(sof),
    .status_output_lines_out(st));
  sop_far_end u_sop_far_end (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .mode_in(mode),
    .rx_valid_out(rxv), .rx_octet_out(rxo), .sof_out(fsof));
  // 25 MHz line octet clock
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // every step lands 1 ns past the edge, after the design has settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // one register access; read data stands only in the cycle after the strobe
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    {cs, wr, rd, addr, wd} = {1'b1, w, !w, a, d};
    tick(1);
    got = rdata;
    {cs, wr, rd} = 3'b000;
    tick(1);
  endtask
  // bounded wait for a frame start, ours or the far end's
  task automatic wait_sof(input logic far);
    tick(1);
    for (int i = 0; i < 3000 && (far ? fsof : sof) !== 1'b1; i++) tick(1);
  endtask
  task automatic t_reset();
    `CHK("oof_pin", 1'b1, st[6])
    acc(0, 8'h33, 8'h00);
    `CHK("unmapped", 8'h00, got)
    acc(0, 8'h0D, 8'h00);
    `CHK("tx_line_ctrl", 8'h00, got)
    acc(1, 8'h0C, 8'h20);
  endtask
  task automatic t_trace();
    for (int i = 0; i < 64; i++) acc(1, 8'h68, 8'h40 + 8'(i));
    for (int i = 0; i < 64; i++) begin
      acc(0, 8'h68, 8'h00);
      `CHK("tx_trace", 8'h40 + 8'(i), got)
    end
    wait_sof(0);
    tick(6);
    `CHK("trace_off", 8'h00, tx)
    acc(1, 8'h0C, 8'h00);
    wait_sof(0);
    tick(6);
    `CHK("trace_msg", 2'b01, tx[7:6])
  endtask
  // fill during overhead, when nothing drains, then watch the payload columns
  task automatic t_pay();
    wait_sof(0);
    {pv, pd} = 9'h111;
    tick(1);
    pd = 8'h22;
    tick(1);
    `CHK("pay_ready", 1'b0, prdy)
    pv = 1'b0;
    tick(7);
    `CHK("pay_word0", 8'h11, tx)
    tick(1);
    `CHK("pay_word1", 8'h22, tx)
    tick(1);
    `CHK("pay_empty", 8'h00, tx)
  endtask
  task automatic t_tx();
    logic [31:0] c [6] = '{32'h0, 32'h01000000, 32'h00800000, 32'h00001000,
                           32'h00000040, 32'h00000048};
    logic [7:0]  a1 [6] = '{8'hF6, 8'hF6, 8'h09, 8'h00, 8'hF6, 8'hF6};
    logic [7:0]  h1 [6] = '{8'h62, 8'h6A, 8'h62, 8'h62, 8'h33, 8'hFF};
    for (int i = 0; i < 6; i++) begin
      acc(1, 8'h00, c[i][31:24]);
      acc(1, 8'h06, c[i][23:16]);
      acc(1, 8'h0C, c[i][15:8]);
      acc(1, 8'h0D, c[i][7:0]);
      wait_sof(0);
      `CHK("a1", a1[i], tx)
      tick(3);
      `CHK("a2", c[i][12] ? 8'h00 : 8'h28, tx)
      tick(807);
      `CHK("h1_first", h1[i], tx)
      tick(1);
      `CHK("h1_next", c[i][3] ? 8'hFF : 8'h93, tx)
      tick(5);
      `CHK("h3", c[i][3] ? 8'hFF : 8'h00, tx)
    end
  endtask
  task automatic t_rx();
    repeat (2) wait_sof(0);
    acc(0, 8'h45, 8'h00);
    `CHK("in_frame", 3'b000, got[5:3])
    mode = 2'd1;
    repeat (6) wait_sof(0);
    acc(0, 8'h45, 8'h00);
    `CHK("oof", 1'b1, got[4])
    `CHK("oof_line", 1'b1, st[6])
    mode = 2'd0;
    repeat (2) wait_sof(0);
    acc(0, 8'h45, 8'h00);
    `CHK("reframe", 2'b00, got[4:3])
    acc(1, 8'h00, 8'h04);
    mode = 2'd2;
    repeat (2) wait_sof(0);
    acc(0, 8'h45, 8'h00);
    `CHK("los", 1'b1, got[5])
    `CHK("los_line", 1'b1, st[7])
    mode = 2'd0;
    repeat (3) wait_sof(0);
    acc(0, 8'h45, 8'h00);
    `CHK("los_clear", 1'b0, got[5])
  endtask
  // three far-end frames with one parity bit flipped each
  task automatic t_b1();
    acc(0, 8'h54, 8'h00);
    acc(0, 8'h55, 8'h00);
    wait_sof(1);
    mode = 2'd3;
    repeat (3) wait_sof(1);
    mode = 2'd0;
    repeat (2) wait_sof(1);
    acc(0, 8'h54, 8'h00);
    `CHK("b1_lo", 8'h03, got)
    acc(0, 8'h55, 8'h00);
    `CHK("b1_hi", 8'h00, got)
    acc(0, 8'h54, 8'h00);
    `CHK("b1_restart", 8'h00, got)
    acc(0, 8'h6A, 8'h00);
    `CHK("rx_trace", 8'h5C, got)
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog sized for about 90k cycles of traffic
  initial begin
    #3600000;
    err_count++;
    give_verdict();
  end
  initial begin
    {cs, wr, rd, addr, wd, pv, pd, mode, rst_in} = 31'h1;
    {err_count, cmp_count} = 64'h0;
    tick(8);
    rst_in = 1'b0;
    tick(1);
    t_reset();
    t_trace();
    t_pay();
    t_tx();
    t_rx();
    t_b1();
    give_verdict();
  end
endmodule
bind sop_top sop_chk u_sop_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .cpu_cs_in(cpu_cs_in), .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in),
  .cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
  .tx_octet_out(tx_octet_out), .tx_sof_out(tx_sof_out),
  .status_output_lines_out(status_output_lines_out));
